// file: design/dma_afe_pkg.sv
// Purpose: Shared constants, layouts and helpers for the result-queue DMA pair
// Assumes: 32-bit descriptor words, one aligned word per register
// Notes:   Host register map and source codes are local choices
package dma_afe_pkg;
  // ==========================================================
  // Channels and descriptor layout
  localparam int          NCH       = 24;
  localparam int          CH_W      = 5;
  localparam int          AFE_CHAN  = 17;
  localparam logic [31:0] OFS_SRC   = 32'h0000_0000;
  localparam logic [31:0] OFS_DST   = 32'h0000_0004;
  localparam logic [31:0] OFS_CTL   = 32'h0000_0008;
  localparam logic [31:0] ALT_AREA  = 32'h0000_0100;
  localparam int          DESC_SH   = 4;
  localparam int          CNT_LSB   = 4;
  localparam int          CNT_MSB   = 13;
  localparam int          CNT_W     = CNT_MSB - CNT_LSB + 1;
  localparam int          INC_LSB   = 30;
  localparam int          INC_MSB   = 31;
  localparam logic [1:0]  INC_NONE  = 2'h3;
  // ==========================================================
  // Result queue control fields
  localparam int          QC_FIFO_EN = 11;
  localparam int          QC_REQ_EN  = 12;
  localparam int          QC_SRC_LSB = 13;
  localparam int          QC_SRC_MSB = 15;
  localparam logic [2:0]  SRC_SINC3  = 3'h0;
  localparam logic [2:0]  SRC_XFORM  = 3'h1;
  localparam logic [2:0]  SRC_SINC2  = 3'h2;
  localparam logic [2:0]  SRC_MEAN   = 3'h3;
  localparam int          RES_W      = 18;
  localparam int          PBUS_W     = 16;
  localparam int          FIFO_DEPTH = 8;
  // ==========================================================
  // Host register map (byte offsets)
  localparam int          CFG_EN_BIT   = 0;
  localparam logic [7:0]  REG_CFG      = 8'h00;
  localparam logic [7:0]  REG_CHEN_SET = 8'h04;
  localparam logic [7:0]  REG_CHEN_CLR = 8'h08;
  localparam logic [7:0]  REG_BASE     = 8'h0C;
  localparam logic [7:0]  REG_QCTL     = 8'h10;
  localparam logic [7:0]  REG_DONE     = 8'h14;
  localparam logic [7:0]  REG_ALT      = 8'h18;
  localparam int          MEM_SEL_BIT  = 12;

  // Descriptor word address: base + channel slot + alternate area + word
  function automatic logic [31:0] desc_addr(input logic [31:0]     base,
                                            input logic [CH_W-1:0] ch,
                                            input logic            alt,
                                            input logic [31:0]     ofs);
    logic [31:0] slot;
    slot = {{(32-CH_W-DESC_SH){1'b0}}, ch, {DESC_SH{1'b0}}};
    return base + slot + (alt ? ALT_AREA : 32'h0000_0000) + ofs;
  endfunction

  // Destination step in bytes from the increment code
  function automatic logic [31:0] step_of(input logic [1:0] inc);
    return (inc == INC_NONE) ? 32'h0000_0000 : (32'h0000_0001 << inc);
  endfunction
endpackage

// file: design/dma_link_if.sv
// Purpose: Link between the DMA device end and its host/memory end
// Assumes: One clock, synchronous active-high reset
// Notes:   No clocking block; each end drives its own signals from flops
`timescale 1ns/100ps
interface dma_link_if (
  input wire logic clk_i,
  input wire logic rst_i
);
  logic                             dma_en;
  logic [dma_afe_pkg::NCH-1:0]      chan_en;
  logic [dma_afe_pkg::NCH-1:0]      alt_sel;
  logic [31:0]                      base_ptr;
  logic [15:0]                      queue_ctl;
  logic [dma_afe_pkg::NCH-1:0]      done;
  logic                             mem_req;
  logic                             mem_we;
  logic [31:0]                      mem_addr;
  logic [31:0]                      mem_wdata;
  logic                             mem_ack;
  logic [31:0]                      mem_rdata;

  modport dev (
    input  dma_en, chan_en, alt_sel, base_ptr, queue_ctl, mem_ack, mem_rdata,
    output done, mem_req, mem_we, mem_addr, mem_wdata
  );
  modport host (
    output dma_en, chan_en, alt_sel, base_ptr, queue_ctl, mem_ack, mem_rdata,
    input  done, mem_req, mem_we, mem_addr, mem_wdata
  );
endinterface

// file: design/dma_afe_device.sv
// Purpose: DMA controller with the converter result queue on its channel
// Assumes: Peripheral bus answers in the cycle its read strobe is high
// Notes:   Peripheral-to-memory only; one descriptor cached at a time
// Operation
// - Eight-word queue buffers converter results
// - Three-bit field selects the queue source
// - Request while non-empty, both enables set
// - Queue request wired to channel seventeen
// - Count field reached raises completion
// - No transfers unless controller enabled
// - Software enables channel seventeen first
// - Software follows the documented setup order
// - System bus master plus 16-bit bus
// - DMA access may stall processor accesses
// - Completion is one-cycle pulse per channel
// - Primary and alternate descriptor per channel
// - Four words: source, destination, control, spare
// - Descriptor at base plus channel offset
// - Descriptor fetched into cache on request
// - Software leaves descriptor until completion
// - Source end word read, never written
// - Destination end word read, never written
// - Lowest requesting channel number wins
// - Destination step follows control bits
`timescale 1ns/100ps
module dma_afe_device #(
  parameter int DEPTH = dma_afe_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Link to host and memory
  dma_link_if.dev                          link,
  // Converter results
  input  wire logic [15:0]                 sinc3_i,
  input  wire logic                        sinc3_valid_i,
  input  wire logic [15:0]                 sinc2_i,
  input  wire logic                        sinc2_valid_i,
  input  wire logic [15:0]                 mean_i,
  input  wire logic                        mean_valid_i,
  input  wire logic [dma_afe_pkg::RES_W-1:0] xform_re_i,
  input  wire logic [dma_afe_pkg::RES_W-1:0] xform_im_i,
  input  wire logic                        xform_valid_i,
  // Other peripherals
  input  wire logic [dma_afe_pkg::NCH-1:0] periph_req_i,
  input  wire logic [dma_afe_pkg::PBUS_W-1:0] pbus_rdata_i,
  output logic                             pbus_rd_o,
  output logic [31:0]                      pbus_addr_o,
  // Status
  output logic                             overflow_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int RW = dma_afe_pkg::RES_W;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_PREP, S_WAIT, S_READ, S_WRITE} state_t;

  state_t                              state;
  logic [RW-1:0]                       fifo_mem [DEPTH];
  logic [AW-1:0]                       wr_ptr;
  logic [AW-1:0]                       rd_ptr;
  logic [AW:0]                         fill;
  logic [RW-1:0]                       im_hold;
  logic                                im_pend;
  logic                                push;
  logic [RW-1:0]                       push_data;
  logic                                pop;
  logic                                queue_req;
  logic [dma_afe_pkg::NCH-1:0]         req;
  logic [dma_afe_pkg::CH_W-1:0]        winner;
  logic [dma_afe_pkg::CH_W-1:0]        ch;
  logic [1:0]                          fidx;
  logic [31:0]                         src_end;
  logic [31:0]                         dst_end;
  logic [31:0]                         ctl;
  logic [31:0]                         cur_dst;
  logic [dma_afe_pkg::CNT_W:0]         left;
  logic [2:0]                          src_sel;
  logic                                q_en;
  logic                                q_req_en;

  function automatic logic [RW-1:0] ext16(input logic [15:0] v);
    return {{(RW-16){v[15]}}, v};
  endfunction

  assign src_sel  = link.queue_ctl[dma_afe_pkg::QC_SRC_MSB:dma_afe_pkg::QC_SRC_LSB];
  assign q_en     = link.queue_ctl[dma_afe_pkg::QC_FIFO_EN];
  assign q_req_en = link.queue_ctl[dma_afe_pkg::QC_REQ_EN];

  // ==========================================================
  // Result queue source select
  always_comb begin
    push      = 1'b0;
    push_data = '0;
    case (src_sel)
      dma_afe_pkg::SRC_SINC3: begin
        push      = sinc3_valid_i;
        push_data = ext16(sinc3_i);
      end
      dma_afe_pkg::SRC_SINC2: begin
        push      = sinc2_valid_i;
        push_data = ext16(sinc2_i);
      end
      dma_afe_pkg::SRC_MEAN: begin
        push      = mean_valid_i;
        push_data = ext16(mean_i);
      end
      dma_afe_pkg::SRC_XFORM: begin
        push      = im_pend | xform_valid_i;
        push_data = im_pend ? im_hold : xform_re_i;
      end
      default: begin
        push      = 1'b0;
        push_data = '0;
      end
    endcase
    push = push & q_en;
  end

  // Imaginary part follows real part one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      im_pend <= 1'b0;
      im_hold <= '0;
    end else if (q_en && src_sel == dma_afe_pkg::SRC_XFORM && xform_valid_i
                 && !im_pend) begin
      im_pend <= 1'b1;
      im_hold <= xform_im_i;
    end else begin
      im_pend <= 1'b0;
    end
  end

  // ==========================================================
  // Result queue storage
  assign pop       = (state == S_READ) && (ch == dma_afe_pkg::AFE_CHAN[dma_afe_pkg::CH_W-1:0]);
  assign queue_req = q_en && q_req_en && (fill != '0);

  always_ff @(posedge clk_i) begin
    if (push && fill != DEPTH[AW:0]) begin
      fifo_mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !q_en) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      fill       <= '0;
    end else begin
      if (push && fill != DEPTH[AW:0]) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      fill <= fill + {{AW{1'b0}}, (push && fill != DEPTH[AW:0])} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_o <= 1'b0;
    end else if (push && fill == DEPTH[AW:0]) begin
      overflow_o <= 1'b1;
    end
  end

  // ==========================================================
  // Request gathering and arbitration
  always_comb begin
    req                        = periph_req_i;
    req[dma_afe_pkg::AFE_CHAN] = queue_req;
    req                        = req & link.chan_en;
    winner                     = '0;
    for (int i = dma_afe_pkg::NCH - 1; i >= 0; i--) begin
      if (req[i]) begin
        winner = i[dma_afe_pkg::CH_W-1:0];
      end
    end
  end

  // ==========================================================
  // Transfer sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state          <= S_IDLE;
      ch             <= '0;
      fidx           <= '0;
      src_end        <= '0;
      dst_end        <= '0;
      ctl            <= '0;
      cur_dst        <= '0;
      left           <= '0;
      link.mem_req   <= 1'b0;
      link.mem_we    <= 1'b0;
      link.mem_addr  <= '0;
      link.mem_wdata <= '0;
      pbus_rd_o      <= 1'b0;
      pbus_addr_o    <= '0;
    end else begin
      pbus_rd_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (link.dma_en && req != '0) begin
            ch            <= winner;
            fidx          <= '0;
            link.mem_req  <= 1'b1;
            link.mem_we   <= 1'b0;
            link.mem_addr <= dma_afe_pkg::desc_addr(link.base_ptr, winner,
                               link.alt_sel[winner], dma_afe_pkg::OFS_SRC);
            state         <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (link.mem_ack) begin
            case (fidx)
              2'h0:    src_end <= link.mem_rdata;
              2'h1:    dst_end <= link.mem_rdata;
              default: ctl     <= link.mem_rdata;
            endcase
            fidx          <= fidx + 2'h1;
            link.mem_addr <= link.mem_addr + dma_afe_pkg::OFS_DST;
            if (fidx == 2'h2) begin
              link.mem_req <= 1'b0;
              state        <= S_PREP;
            end
          end
        end
        S_PREP: begin
          left    <= {1'b0, ctl[dma_afe_pkg::CNT_MSB:dma_afe_pkg::CNT_LSB]} + 1'b1;
          cur_dst <= dst_end - (step_mul(ctl));
          state   <= S_WAIT;
        end
        S_WAIT: begin
          if (link.dma_en && req[ch]) begin
            pbus_rd_o   <= (ch != dma_afe_pkg::AFE_CHAN[dma_afe_pkg::CH_W-1:0]);
            pbus_addr_o <= src_end;
            state       <= S_READ;
          end
        end
        S_READ: begin
          link.mem_wdata <= pop ? {{(32-RW){fifo_mem[rd_ptr][RW-1]}}, fifo_mem[rd_ptr]}
                                : {{(32-dma_afe_pkg::PBUS_W){1'b0}}, pbus_rdata_i};
          link.mem_req   <= 1'b1;
          link.mem_we    <= 1'b1;
          link.mem_addr  <= cur_dst;
          state          <= S_WRITE;
        end
        S_WRITE: begin
          if (link.mem_ack) begin
            link.mem_req <= 1'b0;
            link.mem_we  <= 1'b0;
            cur_dst      <= cur_dst + dma_afe_pkg::step_of(
                              ctl[dma_afe_pkg::INC_MSB:dma_afe_pkg::INC_LSB]);
            left         <= left - 1'b1;
            state        <= (left == 1) ? S_IDLE : S_WAIT;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Completion pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.done <= '0;
    end else begin
      link.done <= '0;
      if (state == S_WRITE && link.mem_ack && left == 1) begin
        link.done[ch] <= 1'b1;
      end
    end
  end

  // First destination address lies count-minus-one steps below the end
  function automatic logic [31:0] step_mul(input logic [31:0] c);
    logic [31:0] n;
    n = {{(32-dma_afe_pkg::CNT_W){1'b0}}, c[dma_afe_pkg::CNT_MSB:dma_afe_pkg::CNT_LSB]};
    return (c[dma_afe_pkg::INC_MSB:dma_afe_pkg::INC_LSB] == dma_afe_pkg::INC_NONE)
           ? 32'h0000_0000 : (n << c[dma_afe_pkg::INC_MSB:dma_afe_pkg::INC_LSB]);
  endfunction
endmodule // dma_afe_device

// file: design/dma_afe_host.sv
// Purpose: Host end: Wishbone register block plus system memory for the DMA
// Assumes: Classic Wishbone single cycles; memory window selected by address
// Notes:   A pending DMA memory access stalls processor memory accesses
`timescale 1ns/100ps
module dma_afe_host #(
  parameter int MEM_WORDS = 1024
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Link to the DMA device
  dma_link_if.host         link,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  localparam int MW = $clog2(MEM_WORDS);
  localparam int N  = dma_afe_pkg::NCH;

  logic [31:0]   mem [MEM_WORDS];
  logic          cfg_en;
  logic [N-1:0]  chan_en;
  logic [N-1:0]  alt_sel;
  logic [31:0]   base_ptr;
  logic [15:0]   qctl;
  logic [N-1:0]  done_sts;
  logic          mem_ack;
  logic [31:0]   mem_rdata;
  logic          wb_req;
  logic          wb_mem;
  logic          wr_now;
  logic [7:0]    reg_ofs;
  logic [N-1:0]  set_w;
  logic [N-1:0]  clr_w;
  logic [MW-1:0] wb_idx;
  logic [MW-1:0] dma_idx;
  logic [31:0]   reg_rd;

  assign link.dma_en    = cfg_en;
  assign link.chan_en   = chan_en;
  assign link.alt_sel   = alt_sel;
  assign link.base_ptr  = base_ptr;
  assign link.queue_ctl = qctl;
  assign link.mem_ack   = mem_ack;
  assign link.mem_rdata = mem_rdata;

  assign wb_req  = wb_cyc_i && wb_stb_i;
  assign wb_mem  = wb_adr_i[dma_afe_pkg::MEM_SEL_BIT];
  assign wr_now  = wb_req && wb_we_i && wb_ack_o;
  assign reg_ofs = wb_adr_i[7:0];
  assign wb_idx  = wb_adr_i[MW+1:2];
  assign dma_idx = link.mem_addr[MW+1:2];
  assign set_w   = (wr_now && !wb_mem && reg_ofs == dma_afe_pkg::REG_CHEN_SET)
                   ? wb_dat_i[N-1:0] : '0;
  assign clr_w   = (wr_now && !wb_mem && reg_ofs == dma_afe_pkg::REG_CHEN_CLR)
                   ? wb_dat_i[N-1:0] : '0;

  // ==========================================================
  // Memory port: DMA has priority over the processor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_ack   <= 1'b0;
      mem_rdata <= '0;
    end else begin
      mem_ack   <= link.mem_req && !mem_ack;
      mem_rdata <= mem[dma_idx];
    end
  end

  always_ff @(posedge clk_i) begin
    if (link.mem_req && link.mem_we && mem_ack) begin
      mem[dma_idx] <= link.mem_wdata;
    end else if (wr_now && wb_mem) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          mem[wb_idx][8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  // ==========================================================
  // Wishbone answer; memory window waits while DMA is pending
  always_comb begin
    case (reg_ofs)
      dma_afe_pkg::REG_CFG:      reg_rd = {31'h0000_0000, cfg_en};
      dma_afe_pkg::REG_CHEN_SET: reg_rd = {{(32-N){1'b0}}, chan_en};
      dma_afe_pkg::REG_CHEN_CLR: reg_rd = {{(32-N){1'b0}}, chan_en};
      dma_afe_pkg::REG_BASE:     reg_rd = base_ptr;
      dma_afe_pkg::REG_QCTL:     reg_rd = {16'h0000, qctl};
      dma_afe_pkg::REG_DONE:     reg_rd = {{(32-N){1'b0}}, done_sts};
      dma_afe_pkg::REG_ALT:      reg_rd = {{(32-N){1'b0}}, alt_sel};
      default:                   reg_rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o && !(wb_mem && link.mem_req);
      wb_dat_o <= wb_mem ? mem[wb_idx] : reg_rd;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_en   <= 1'b0;
      base_ptr <= '0;
      qctl     <= '0;
      alt_sel  <= '0;
    end else if (wr_now && !wb_mem) begin
      case (reg_ofs)
        dma_afe_pkg::REG_CFG:  cfg_en   <= wb_dat_i[dma_afe_pkg::CFG_EN_BIT];
        dma_afe_pkg::REG_BASE: base_ptr <= wb_dat_i;
        dma_afe_pkg::REG_QCTL: qctl     <= wb_dat_i[15:0];
        dma_afe_pkg::REG_ALT:  alt_sel  <= wb_dat_i[N-1:0];
        default:               cfg_en   <= cfg_en;
      endcase
    end
  end

  // Enable cleared at completion; a set in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_en <= '0;
    end else begin
      chan_en <= (chan_en & ~clr_w & ~link.done) | set_w;
    end
  end

  // Sticky completion status, write one to clear; new pulse wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_sts <= '0;
    end else begin
      done_sts <= (done_sts & ~((wr_now && !wb_mem && reg_ofs == dma_afe_pkg::REG_DONE)
                  ? wb_dat_i[N-1:0] : '0)) | link.done;
    end
  end
endmodule // dma_afe_host

// file: testbench/dma_link_properties.sv
// Purpose: Link checks for the result-queue DMA pair
// Assumes: Only the queue channel carries traffic
// Notes:   Sees the link signals only
`timescale 1ns/100ps
module dma_link_properties (
  // Clock and reset
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  // Link
  input wire logic                          dma_en,
  input wire logic [dma_afe_pkg::NCH-1:0]   chan_en,
  input wire logic [dma_afe_pkg::NCH-1:0]   alt_sel,
  input wire logic [31:0]                   base_ptr,
  input wire logic [dma_afe_pkg::NCH-1:0]   done,
  input wire logic                          mem_req,
  input wire logic                          mem_we,
  input wire logic [31:0]                   mem_addr,
  input wire logic                          mem_ack,
  input wire logic [31:0]                   mem_rdata
);
  localparam int Q = dma_afe_pkg::AFE_CHAN;
  // =====
  // Cached descriptor and write count
  logic [31:0] dst;
  logic [9:0]  cf;
  logic [1:0]  inc;
  logic [10:0] wcnt;
  logic [31:0] step;
  logic        wack;
  assign step = (inc == 2'h3) ? 32'h0 : (32'h1 << inc);
  assign wack = mem_ack && mem_we;
  always_ff @(posedge clk_i) begin
    if (rst_i || done[Q]) begin
      wcnt <= 11'h000;
    end else if (wack) begin
      wcnt <= wcnt + 11'h001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (mem_ack && !mem_we && mem_addr[3:2] == 2'h1) begin
      dst <= mem_rdata;
    end
    if (mem_ack && !mem_we && mem_addr[3:2] == 2'h2) begin
      cf  <= mem_rdata[13:4];
      inc <= mem_rdata[31:30];
    end
  end
  // =====
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  done_pulse_a: assert property (done[Q] |=> !done[Q])
    else $error("done wider than one cycle");
  other_done_a: assert property ($countones(done) == int'(done[Q]))
    else $error("done on a foreign channel");
  start_gate_a: assert property ($rose(mem_req) |-> dma_en && chan_en[Q])
    else $error("fetch while disabled");
  desc_base_a: assert property ($rose(mem_req) && !mem_we |->
    mem_addr == base_ptr + 32'h110 + (alt_sel[Q] ? 32'h100 : 32'h0))
    else $error("descriptor fetched from wrong slot");
  desc_order_a: assert property (mem_ack && !mem_we && mem_addr[3:2] != 2'h2 |=>
    mem_req && !mem_we && mem_addr == $past(mem_addr) + 32'h4)
    else $error("descriptor words out of order");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request dropped before answer");
  no_desc_wr_a: assert property (mem_req && mem_we |-> mem_addr - base_ptr >= 32'h280)
    else $error("write into descriptor area");
  wr_addr_a: assert property (mem_req && mem_we |->
    mem_addr == dst - {22'h0, cf} * step + {21'h0, wcnt} * step)
    else $error("destination address wrong");
  xfer_count_a: assert property (done[Q] |-> wcnt + {10'h0, wack} == {1'b0, cf} + 11'h1)
    else $error("done at wrong transfer count");
endmodule // dma_link_properties

// file: testbench/afe_fifo_dma_descriptor_engine_tb_top.sv
// Purpose: Register-level tests of the result-queue DMA pair
// Assumes: Base pointer zero, memory window at 0x1000
// Notes:   Other channels idle
`timescale 1ns/100ps
module afe_fifo_dma_descriptor_engine_tb_top;
  // =====
  // Signals
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we  = 1'b0;
  logic [31:0] wb_adr = 32'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rd;
  logic        wb_ack;
  logic [15:0] res    = 16'h0;
  logic [2:0]  vld    = 3'h0;
  logic [17:0] xre    = 18'h0;
  logic [17:0] xim    = 18'h0;
  logic        xv     = 1'b0;
  logic        ovf;
  logic        prd;
  logic        prd_seen    = 1'b0;
  logic [31:0] pa;
  int          err_total   = 0;
  int          check_count = 0;
  dma_link_if link (.clk_i(clk_i), .rst_i(rst_i));
  dma_afe_device u_dma_afe_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .sinc3_i(res), .sinc3_valid_i(vld[0]), .sinc2_i(res), .sinc2_valid_i(vld[1]),
    .mean_i(res), .mean_valid_i(vld[2]), .xform_re_i(xre), .xform_im_i(xim),
    .xform_valid_i(xv), .periph_req_i('0), .pbus_rdata_i(16'h0), .pbus_rd_o(prd),
    .pbus_addr_o(pa), .overflow_o(ovf));
  dma_afe_host u_dma_afe_host (.clk_i(clk_i), .rst_i(rst_i), .link(link), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
    .wb_sel_i(4'hF), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack));
  dma_link_properties u_dma_link_properties (.clk_i(clk_i), .rst_i(rst_i),
    .dma_en(link.dma_en), .chan_en(link.chan_en), .alt_sel(link.alt_sel),
    .base_ptr(link.base_ptr), .done(link.done), .mem_req(link.mem_req), .mem_we(link.mem_we),
    .mem_addr(link.mem_addr), .mem_ack(link.mem_ack), .mem_rdata(link.mem_rdata));
  initial forever #10 clk_i = ~clk_i;
  // Queue channel never strobes the peripheral bus
  always @(posedge clk_i) begin
    if (prd) prd_seen <= 1'b1;
  end
  // =====
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    q = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rw(input logic [7:0] r, input logic [31:0] d);
    wr({24'h0, r}, d);
  endtask
  task automatic rr(input logic [7:0] r, output logic [31:0] q);
    wb(1'b0, {24'h0, r}, 32'h0, q);
  endtask
  // Valid pulses two cycles apart, as the transform needs
  task automatic push(input logic [2:0] s, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      res <= 16'h1230 + 16'(k);
      xre <= 18'h15A50;
      xim <= 18'h16B60;
      vld <= {s == dma_afe_pkg::SRC_MEAN, s == dma_afe_pkg::SRC_SINC2, s == 3'h0};
      xv  <= (s == dma_afe_pkg::SRC_XFORM);
      @(posedge clk_i);
      vld <= 3'h0;
      xv  <= 1'b0;
    end
  endtask
  // One two-transfer run from source s, primary or alternate descriptor
  task automatic run(input logic [2:0] s, input logic alt);
    logic [31:0] d;
    logic [31:0] t;
    logic [31:0] q;
    logic        x;
    x = (s == dma_afe_pkg::SRC_XFORM);
    d = alt ? 32'h1210 : 32'h1110;
    t = 32'h404 + 32'(s) * 32'h10;
    rw(dma_afe_pkg::REG_CHEN_SET, 32'h1 << dma_afe_pkg::AFE_CHAN);
    rw(dma_afe_pkg::REG_ALT, 32'(alt) << dma_afe_pkg::AFE_CHAN);
    wr(d, 32'h40);
    wr(d + 32'h4, t);
    wr(d + 32'h8, 32'h8000_0010);
    wr(d + 32'hC, 32'h0);
    rw(dma_afe_pkg::REG_QCTL, {16'h0, s, 13'h0});
    rw(dma_afe_pkg::REG_QCTL, {16'h0, s, 2'h3, 11'h0});
    push(s, x ? 1 : 2);
    for (int i = 0; i < 50 && q[17] !== 1'b1; i++) rr(dma_afe_pkg::REG_DONE, q);
    chk(q, 32'h0002_0000);
    chk(pa, 32'h0000_0040);
    for (int k = 0; k < 2; k++) begin
      rd_mem(t - 32'h4 + 32'(k) * 32'h4, q);
      chk(q, x ? {14'h0, k ? 18'h16B60 : 18'h15A50} : 32'h1230 + 32'(k));
    end
    rw(dma_afe_pkg::REG_DONE, 32'h0002_0000);
    rr(dma_afe_pkg::REG_DONE, q);
    chk(q, 32'h0);
    rw(dma_afe_pkg::REG_QCTL, 32'h0);
    $display("test source %0d finished", s);
  endtask
  task automatic rd_mem(input logic [31:0] a, output logic [31:0] q);
    wb(1'b0, 32'h1000 + a, 32'h0, q);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // =====
  // Sequence
  initial begin
    logic [31:0] q;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rr(dma_afe_pkg::REG_CFG, q);
    chk(q, 32'h0);
    rw(8'h1C, 32'hFFFF_FFFF);
    rr(8'h1C, q);
    chk(q, 32'h0);
    $display("test register map finished");
    rw(dma_afe_pkg::REG_CFG, 32'h1);
    for (int s = 0; s < 4; s++) run(3'(s), s == 1);
    rw(dma_afe_pkg::REG_CFG, 32'h0);
    rw(dma_afe_pkg::REG_CHEN_SET, 32'h1 << dma_afe_pkg::AFE_CHAN);
    rw(dma_afe_pkg::REG_QCTL, 32'h1800);
    push(3'h0, 2);
    repeat (40) @(posedge clk_i);
    rr(dma_afe_pkg::REG_DONE, q);
    chk(q, 32'h0);
    chk({31'h0, prd_seen}, 32'h0);
    $display("test disabled controller finished");
    rw(dma_afe_pkg::REG_QCTL, 32'h0);
    rw(dma_afe_pkg::REG_QCTL, 32'h0800);
    push(3'h0, 8);
    chk({31'h0, ovf}, 32'h0);
    push(3'h0, 1);
    @(posedge clk_i);
    chk({31'h0, ovf}, 32'h1);
    $display("test queue depth finished");
    stop_test;
  end
  initial begin
    #1000000;
    err_total++;
    stop_test;
  end
endmodule // afe_fifo_dma_descriptor_engine_tb_top
